// file: verilog/umc_pkg.sv
// constants, field layouts and types of the serial channel mode, rate and control registers
// assumes a 16-bit register port with word-sized registers at the offsets below
package umc_pkg;

    localparam int UMC_AW = 4;
    localparam int UMC_DW = 16;

    // register offsets
    localparam logic [UMC_AW-1:0] UMC_OFS_MODE = 4'h0;
    localparam logic [UMC_AW-1:0] UMC_OFS_RATE = 4'h4;
    localparam logic [UMC_AW-1:0] UMC_OFS_CTL = 4'h8;

    // frame mode field positions
    localparam int UMC_MODE_PULLUP = 6;
    localparam int UMC_MODE_DRIVE_OD = 5;
    localparam int UMC_MODE_IRDA = 4;
    localparam int UMC_MODE_CHAR8 = 3;
    localparam int UMC_MODE_PAR_EN = 2;
    localparam int UMC_MODE_PAR_ODD = 1;
    localparam int UMC_MODE_STOP = 0;
    localparam int UMC_MODE_W = 7;

    // rate field positions
    localparam int UMC_RATE_INT_LSB = 0;
    localparam int UMC_RATE_INT_W = 8;
    localparam int UMC_RATE_FINE_LSB = 8;
    localparam int UMC_RATE_FINE_W = 4;
    localparam int UMC_RATE_W = 12;

    // control field positions
    localparam int UMC_CTL_ENABLE = 0;
    localparam int UMC_CTL_SRST = 1;

    // reset values
    localparam logic [UMC_MODE_W-1:0] UMC_MODE_RST = 7'h00;
    localparam logic [UMC_RATE_W-1:0] UMC_RATE_RST = 12'h000;
    localparam logic [UMC_DW-1:0] UMC_RDATA_RST = 16'h0000;
    localparam logic UMC_TX_IDLE = 1'b1;

    // soft reset processing time
    localparam int UMC_SRST_TIME_NS = 16;
    localparam int UMC_CLK_PERIOD_NS = 4;
    localparam int UMC_SRST_CYCLES = (UMC_SRST_TIME_NS + UMC_CLK_PERIOD_NS - 1) / UMC_CLK_PERIOD_NS;

    typedef struct packed {
        logic rx_pullup_enable;
        logic tx_drive_mode;
        logic infrared_mode_enable;
        logic character_length_select;
        logic parity_enable;
        logic parity_sense_select;
        logic stop_length_select;
    } umc_frame_cfg_t;

    typedef struct packed {
        logic [UMC_RATE_FINE_W-1:0] rate_fine_adjust;
        logic [UMC_RATE_INT_W-1:0] rate_integer_setting;
    } umc_rate_t;

    typedef enum logic [1:0] {
        UMC_SR_IDLE = 2'h0,
        UMC_SR_RUN = 2'h1,
        UMC_SR_DONE = 2'h3
    } umc_sr_state_t;

endpackage : umc_pkg

// file: verilog/umc_soft_reset.sv
// soft reset sequencer: holds busy for a fixed number of cycles after a start
// assumes start comes from the register write decode of the same clock
`timescale 1ns/1ps
module umc_soft_reset
    import umc_pkg::*;
#(
    parameter int LEN = UMC_SRST_CYCLES
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic start_i,
    output logic busy_o
);

    localparam int CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(LEN - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;

    umc_sr_state_t state_r;
    umc_sr_state_t state_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic busy_r;
    logic busy_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            UMC_SR_IDLE: begin
                if (start_i) begin
                    state_nxt = UMC_SR_RUN;
                    cnt_nxt = CNT_ZERO;
                end
            end
            UMC_SR_RUN: begin
                if (cnt_r == CNT_LAST) begin
                    state_nxt = UMC_SR_DONE;
                end else begin
                    cnt_nxt = cnt_r + CW'(1);
                end
            end
            UMC_SR_DONE: begin
                // a new start in the finishing cycle wins over the self-clear
                state_nxt = start_i ? UMC_SR_RUN : UMC_SR_IDLE;
                cnt_nxt = CNT_ZERO;
            end
            default: begin
                state_nxt = UMC_SR_IDLE;
                cnt_nxt = CNT_ZERO;
            end
        endcase
        busy_nxt = (state_nxt == UMC_SR_RUN);
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= UMC_SR_IDLE;
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign busy_o = busy_r;

    sequence s_run_window;
        busy_o [*4] ##1 !busy_o;
    endsequence

    a_busy_length: assert property (@(posedge clock_i) disable iff (reset_i)
        ($rose(busy_o) && !start_i) |-> s_run_window)
        else $error("soft reset busy not held for the set length");

endmodule : umc_soft_reset

// file: verilog/umc_regs.sv
// mode, rate and control registers of one serial channel, with pin control
// assumes a single-cycle strobe register port and a datapath that honours the outputs
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
module umc_regs
    import umc_pkg::*;
#(
    parameter int SRST_LEN = UMC_SRST_CYCLES
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [UMC_AW-1:0] addr_i,
    input wire logic [UMC_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [UMC_DW-1:0] rdata_o,
    input wire logic tx_data_i,
    output logic serial_tx_pin_o,
    output logic serial_tx_pin_oe_n_o,
    output logic rx_pullup_enable_o,
    output umc_frame_cfg_t frame_cfg_o,
    output umc_rate_t rate_o,
    output logic channel_enable_o,
    output logic channel_clk_en_o,
    output logic channel_run_o,
    output logic txrx_soft_reset_o
);

    // address decode shared by the write and read paths
    function automatic logic hit(input logic [UMC_AW-1:0] a, input logic [UMC_AW-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // register state
    umc_frame_cfg_t mode_r;
    umc_frame_cfg_t mode_nxt;
    umc_rate_t rate_r;
    umc_rate_t rate_nxt;
    logic enable_r;
    logic enable_nxt;
    logic [UMC_DW-1:0] rdata_r;
    logic [UMC_DW-1:0] rdata_nxt;

    // pin and status state
    logic pullup_r;
    logic pullup_nxt;
    logic tx_out_r;
    logic tx_out_nxt;
    logic tx_oe_n_r;
    logic tx_oe_n_nxt;
    logic clk_en_r;
    logic clk_en_nxt;
    logic run_r;
    logic run_nxt;
    logic soft_rst_r;
    logic soft_rst_nxt;

    logic srst_start;
    logic srst_busy;

    // configuration writes; mode and rate take any write, software keeps them
    // quiet while enabled since a mid-frame change would corrupt the frame
    always_comb begin
        mode_nxt = mode_r;
        rate_nxt = rate_r;
        enable_nxt = enable_r;
        if (wr_i && hit(addr_i, UMC_OFS_MODE)) begin
            mode_nxt.rx_pullup_enable = wdata_i[UMC_MODE_PULLUP];
            mode_nxt.tx_drive_mode = wdata_i[UMC_MODE_DRIVE_OD];
            mode_nxt.infrared_mode_enable = wdata_i[UMC_MODE_IRDA];
            mode_nxt.character_length_select = wdata_i[UMC_MODE_CHAR8];
            mode_nxt.parity_enable = wdata_i[UMC_MODE_PAR_EN];
            mode_nxt.parity_sense_select = wdata_i[UMC_MODE_PAR_ODD];
            mode_nxt.stop_length_select = wdata_i[UMC_MODE_STOP];
        end
        if (wr_i && hit(addr_i, UMC_OFS_RATE)) begin
            rate_nxt.rate_fine_adjust = wdata_i[UMC_RATE_FINE_LSB +: UMC_RATE_FINE_W];
            rate_nxt.rate_integer_setting = wdata_i[UMC_RATE_INT_LSB +: UMC_RATE_INT_W];
        end
        if (wr_i && hit(addr_i, UMC_OFS_CTL)) begin
            enable_nxt = wdata_i[UMC_CTL_ENABLE];
        end
    end

    // soft reset leaves the configuration untouched, only the sequencer starts
    assign srst_start = wr_i && hit(addr_i, UMC_OFS_CTL) && wdata_i[UMC_CTL_SRST];

    umc_soft_reset #(
        .LEN(SRST_LEN)
    ) u_soft_reset (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .start_i(srst_start),
        .busy_o(srst_busy)
    );

    // read path: data stand in the cycle after the strobe only
    always_comb begin
        rdata_nxt = UMC_RDATA_RST;
        if (rd_i) begin
            if (hit(addr_i, UMC_OFS_MODE)) begin
                rdata_nxt[UMC_MODE_W-1:0] = mode_r;
            end else if (hit(addr_i, UMC_OFS_RATE)) begin
                rdata_nxt[UMC_RATE_W-1:0] = rate_r;
            end else if (hit(addr_i, UMC_OFS_CTL)) begin
                rdata_nxt[UMC_CTL_ENABLE] = enable_r;
                rdata_nxt[UMC_CTL_SRST] = srst_busy;
            end
        end
    end

    // pins and channel control
    always_comb begin
        pullup_nxt = mode_r.rx_pullup_enable;
        clk_en_nxt = enable_r;
        // soft reset holds the channel idle so the datapath restarts cleanly
        run_nxt = enable_r && !srst_busy;
        soft_rst_nxt = srst_busy;
        // idle mark while not running so the line never shows a false start bit
        tx_out_nxt = run_nxt ? tx_data_i : UMC_TX_IDLE;
        if (mode_r.tx_drive_mode) begin
            tx_oe_n_nxt = tx_out_nxt;
            tx_out_nxt = 1'b0;
        end else begin
            tx_oe_n_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mode_r <= UMC_MODE_RST;
            rate_r <= UMC_RATE_RST;
            enable_r <= 1'b0;
            rdata_r <= UMC_RDATA_RST;
            pullup_r <= 1'b0;
            tx_out_r <= UMC_TX_IDLE;
            tx_oe_n_r <= 1'b0;
            clk_en_r <= 1'b0;
            run_r <= 1'b0;
            soft_rst_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            rate_r <= rate_nxt;
            enable_r <= enable_nxt;
            rdata_r <= rdata_nxt;
            pullup_r <= pullup_nxt;
            tx_out_r <= tx_out_nxt;
            tx_oe_n_r <= tx_oe_n_nxt;
            clk_en_r <= clk_en_nxt;
            run_r <= run_nxt;
            soft_rst_r <= soft_rst_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign frame_cfg_o = mode_r;
    assign rate_o = rate_r;
    assign channel_enable_o = enable_r;
    assign rx_pullup_enable_o = pullup_r;
    assign serial_tx_pin_o = tx_out_r;
    assign serial_tx_pin_oe_n_o = tx_oe_n_r;
    assign channel_clk_en_o = clk_en_r;
    assign channel_run_o = run_r;
    assign txrx_soft_reset_o = soft_rst_r;

    // checks
    sequence s_mode_write(int pos);
        wr_i && hit(addr_i, UMC_OFS_MODE) && wdata_i[pos];
    endsequence

    sequence s_ctl_srst_write;
        wr_i && hit(addr_i, UMC_OFS_CTL) && wdata_i[UMC_CTL_SRST];
    endsequence

    sequence s_mode_wr;
        wr_i && hit(addr_i, UMC_OFS_MODE);
    endsequence

    sequence s_ctl_wr;
        wr_i && hit(addr_i, UMC_OFS_CTL);
    endsequence

    a_pullup_follows: assert property (@(posedge clock_i) disable iff (reset_i)
        s_mode_write(UMC_MODE_PULLUP) |-> ##2 rx_pullup_enable_o)
        else $error("pull-up did not follow its mode field");

    // run in the next cycle tells whether the line carried data or the idle mark
    a_open_drain_drive: assert property (@(posedge clock_i) disable iff (reset_i)
        frame_cfg_o.tx_drive_mode |=> (!serial_tx_pin_o &&
        (serial_tx_pin_oe_n_o == (channel_run_o ? $past(tx_data_i) : UMC_TX_IDLE))))
        else $error("open-drain pin drove high");

    a_push_pull_drive: assert property (@(posedge clock_i) disable iff (reset_i)
        !frame_cfg_o.tx_drive_mode |=>
        (!serial_tx_pin_oe_n_o && (serial_tx_pin_o == (channel_run_o ? $past(tx_data_i) : UMC_TX_IDLE))))
        else $error("push-pull pin not driven with the data");

    a_irda_written: assert property (@(posedge clock_i) disable iff (reset_i)
        (wr_i && hit(addr_i, UMC_OFS_MODE)) |=> (frame_cfg_o.infrared_mode_enable == $past(wdata_i[UMC_MODE_IRDA])))
        else $error("infrared field not taken from the write");

    a_rate_reads_back: assert property (@(posedge clock_i) disable iff (reset_i)
        (rd_i && hit(addr_i, UMC_OFS_RATE)) |=>
        (rdata_o[UMC_DW-1:UMC_RATE_W] == '0) && (rdata_o[UMC_RATE_W-1:0] == $past(rate_o)))
        else $error("rate read back wrong or upper bits set");

    a_srst_starts: assert property (@(posedge clock_i) disable iff (reset_i)
        s_ctl_srst_write |=> ##1 txrx_soft_reset_o)
        else $error("soft reset did not start on a write of 1");

    a_srst_zero_inert: assert property (@(posedge clock_i) disable iff (reset_i)
        (wr_i && hit(addr_i, UMC_OFS_CTL) && !wdata_i[UMC_CTL_SRST] && !srst_busy && !txrx_soft_reset_o) |=>
        !srst_busy)
        else $error("writing 0 started a soft reset");

    a_srst_reads_busy: assert property (@(posedge clock_i) disable iff (reset_i)
        (rd_i && hit(addr_i, UMC_OFS_CTL)) |=> (rdata_o[UMC_CTL_SRST] == $past(srst_busy)))
        else $error("soft reset field read wrong");

    a_srst_self_clears: assert property (@(posedge clock_i) disable iff (reset_i)
        $rose(srst_busy) |-> ##[1:8] !srst_busy)
        else $error("soft reset never cleared itself");

    a_cfg_kept_srst: assert property (@(posedge clock_i) disable iff (reset_i)
        (srst_busy && !wr_i) |=> ($stable(frame_cfg_o) && $stable(rate_o)))
        else $error("soft reset altered the configuration");

    a_run_needs_enable: assert property (@(posedge clock_i) disable iff (reset_i)
        channel_run_o |-> ($past(enable_r) && !$past(srst_busy)))
        else $error("channel ran while disabled or in soft reset");

    a_clock_gate: assert property (@(posedge clock_i) disable iff (reset_i)
        (wr_i && hit(addr_i, UMC_OFS_CTL)) |-> ##2 (channel_clk_en_o == $past(wdata_i[UMC_CTL_ENABLE], 2)))
        else $error("channel clock enable did not follow the enable field");

    // per-field checks catch a swapped bit position in the write decode
    a_pullup_clears: assert property (@(posedge clock_i) disable iff (reset_i)
        (wr_i && hit(addr_i, UMC_OFS_MODE) && !wdata_i[UMC_MODE_PULLUP]) |-> ##2 !rx_pullup_enable_o)
        else $error("pull-up stayed on after its field was cleared");

    a_drive_written: assert property (@(posedge clock_i) disable iff (reset_i)
        s_mode_wr |=> (frame_cfg_o.tx_drive_mode == $past(wdata_i[UMC_MODE_DRIVE_OD])))
        else $error("drive mode field not taken from the write");

    a_length_written: assert property (@(posedge clock_i) disable iff (reset_i)
        s_mode_wr |=> (frame_cfg_o.character_length_select == $past(wdata_i[UMC_MODE_CHAR8])))
        else $error("length field not taken from the write");

    a_parity_en_written: assert property (@(posedge clock_i) disable iff (reset_i)
        s_mode_wr |=> (frame_cfg_o.parity_enable == $past(wdata_i[UMC_MODE_PAR_EN])))
        else $error("parity enable field not taken from the write");

    a_parity_sense_written: assert property (@(posedge clock_i) disable iff (reset_i)
        s_mode_wr |=> (frame_cfg_o.parity_sense_select == $past(wdata_i[UMC_MODE_PAR_ODD])))
        else $error("parity sense field not taken from the write");

    a_stop_written: assert property (@(posedge clock_i) disable iff (reset_i)
        s_mode_wr |=> (frame_cfg_o.stop_length_select == $past(wdata_i[UMC_MODE_STOP])))
        else $error("stop field not taken from the write");

    a_mode_reads_back: assert property (@(posedge clock_i) disable iff (reset_i)
        (rd_i && hit(addr_i, UMC_OFS_MODE)) |=>
        (rdata_o[UMC_DW-1:UMC_MODE_W] == '0) && (rdata_o[UMC_MODE_W-1:0] == $past(frame_cfg_o)))
        else $error("frame mode read back wrong or upper bits set");

    a_ctl_reads_back: assert property (@(posedge clock_i) disable iff (reset_i)
        (rd_i && hit(addr_i, UMC_OFS_CTL)) |=>
        (rdata_o[UMC_DW-1:UMC_CTL_SRST+1] == '0) && (rdata_o[UMC_CTL_ENABLE] == $past(channel_enable_o)))
        else $error("control read back wrong or upper bits set");

    a_rate_written: assert property (@(posedge clock_i) disable iff (reset_i)
        (wr_i && hit(addr_i, UMC_OFS_RATE)) |=> (rate_o == $past(wdata_i[UMC_RATE_W-1:0])))
        else $error("rate fields not taken from the write");

    a_srst_holds_txrx: assert property (@(posedge clock_i) disable iff (reset_i)
        srst_busy |=> txrx_soft_reset_o)
        else $error("transmit and receive control not held in reset");

    a_txrx_released: assert property (@(posedge clock_i) disable iff (reset_i)
        !srst_busy |=> !txrx_soft_reset_o)
        else $error("transmit and receive control held in reset when idle");

    a_run_when_enabled: assert property (@(posedge clock_i) disable iff (reset_i)
        (channel_enable_o && !srst_busy) |=> channel_run_o)
        else $error("enabled channel did not run");

    a_clock_runs: assert property (@(posedge clock_i) disable iff (reset_i)
        channel_enable_o |=> channel_clk_en_o)
        else $error("operating clock stopped while enabled");

    a_clock_stops: assert property (@(posedge clock_i) disable iff (reset_i)
        !channel_enable_o |=> !channel_clk_en_o)
        else $error("operating clock ran while disabled");

    a_enable_written: assert property (@(posedge clock_i) disable iff (reset_i)
        s_ctl_wr |=> (channel_enable_o == $past(wdata_i[UMC_CTL_ENABLE])))
        else $error("enable field not taken from the write");

endmodule : umc_regs

// file: testbench/umc_regs_test.sv
// self-checking bench for the serial channel mode, rate and control registers
// assumes umc_pkg and umc_regs are compiled first; drives the register port and tx datapath level directly
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); end end
module umc_regs_test;
    import umc_pkg::*;
    localparam int SRST_LEN = 4;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [UMC_AW-1:0] addr_i = '0;
    logic [UMC_DW-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic tx_data_i = 1'b1;
    logic [UMC_DW-1:0] rdata_o;
    logic serial_tx_pin_o;
    logic serial_tx_pin_oe_n_o;
    logic rx_pullup_enable_o;
    umc_frame_cfg_t frame_cfg_o;
    umc_rate_t rate_o;
    logic channel_enable_o;
    logic channel_clk_en_o;
    logic channel_run_o;
    logic txrx_soft_reset_o;
    int n_errors = 0;
    int cmp_count = 0;
    int seed = 49;
    logic rd_seen = 1'b0;
    logic [UMC_DW-1:0] exp_q[$];
    logic [UMC_DW-1:0] exp_rd;

    umc_regs #(.SRST_LEN(SRST_LEN)) dut (
        .clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .tx_data_i(tx_data_i), .serial_tx_pin_o(serial_tx_pin_o),
        .serial_tx_pin_oe_n_o(serial_tx_pin_oe_n_o), .rx_pullup_enable_o(rx_pullup_enable_o),
        .frame_cfg_o(frame_cfg_o), .rate_o(rate_o), .channel_enable_o(channel_enable_o),
        .channel_clk_en_o(channel_clk_en_o), .channel_run_o(channel_run_o), .txrx_soft_reset_o(txrx_soft_reset_o)
    );

    initial begin
        forever #2 clock_i = ~clock_i;
    end

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clock_i);
            wr_i <= 1'b0;
            rd_i <= 1'b0;
        end
    endtask : idle

    task automatic bus_wr(input logic [UMC_AW-1:0] a, input logic [UMC_DW-1:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        addr_i <= a;
        wdata_i <= d;
    endtask : bus_wr

    // expectation is queued with the strobe; the watcher pops it when the answer cycle comes
    task automatic bus_rd(input logic [UMC_AW-1:0] a, input logic [UMC_DW-1:0] e);
        @(posedge clock_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= a;
        exp_q.push_back(e);
    endtask : bus_rd

    // read data stand only in the cycle after the strobe, so look mid-cycle there
    always @(posedge clock_i) rd_seen <= rd_i;
    always @(negedge clock_i) begin
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("unexpected at %0t: got %h exp %h", $time, rdata_o, 16'h0000);
            end else begin
                // pop once: the macro names its expected value twice
                exp_rd = exp_q.pop_front();
                `CHK(rdata_o, exp_rd)
            end
        end
    end

    initial begin
        repeat (50000) @(posedge clock_i);
        n_errors++;
        conclude();
    end

    initial begin
        logic [UMC_DW-1:0] d;
        logic [UMC_DW-1:0] rate_keep;
        logic [UMC_DW-1:0] mode_keep;
        int cnt;
        repeat (4) @(posedge clock_i);
        reset_i <= 1'b0;
        idle(1);
        #1;
        `CHK({serial_tx_pin_o, serial_tx_pin_oe_n_o, channel_enable_o, channel_run_o}, 4'h8)
        bus_rd(UMC_OFS_MODE, 16'h0000);
        bus_rd(UMC_OFS_RATE, 16'h0000);
        bus_rd(UMC_OFS_CTL, 16'h0000);
        bus_rd(4'hC, 16'h0000);
        $display("test reset values done");
        // channel stays disabled through all frame mode and rate writes
        for (int b = 0; b < 8; b++) begin
            d = (b == 7) ? 16'hFFFF : (16'h0001 << b);
            bus_wr(UMC_OFS_MODE, d);
            idle(2);
            #1;
            `CHK(frame_cfg_o, d[6:0])
            `CHK(rx_pullup_enable_o, d[6])
            bus_rd(UMC_OFS_MODE, d & 16'h007F);
        end
        for (int i = 0; i < 6; i++) begin
            d = 16'($random(seed));
            bus_wr(UMC_OFS_MODE, d);
            bus_rd(UMC_OFS_MODE, d & 16'h007F);
            idle(1);
            #1;
            `CHK(frame_cfg_o, d[6:0])
        end
        mode_keep = d & 16'h007F;
        $display("test frame mode done");
        for (int i = 0; i < 6; i++) begin
            d = 16'($random(seed));
            bus_wr(UMC_OFS_RATE, d);
            bus_rd(UMC_OFS_RATE, d & 16'h0FFF);
            idle(1);
            #1;
            `CHK(rate_o, d[11:0])
        end
        rate_keep = d & 16'h0FFF;
        bus_wr(4'hC, 16'hFFFF);
        bus_wr(4'h2, 16'h0000);
        bus_rd(4'hC, 16'h0000);
        bus_rd(UMC_OFS_RATE, rate_keep);
        bus_rd(UMC_OFS_MODE, mode_keep);
        $display("test rate and unmapped done");
        // drive mode times line level, in a small table
        for (int m = 0; m < 2; m++) begin
            for (int v = 0; v < 2; v++) begin
                bus_wr(UMC_OFS_CTL, 16'h0000);
                bus_wr(UMC_OFS_MODE, m ? 16'h0020 : 16'h0000);
                bus_wr(UMC_OFS_CTL, 16'h0001);
                tx_data_i <= v[0];
                idle(5);
                #1;
                `CHK({serial_tx_pin_o, serial_tx_pin_oe_n_o}, m ? {1'b0, v[0]} : {v[0], 1'b0})
                `CHK({channel_enable_o, channel_clk_en_o, channel_run_o}, 3'h7)
                bus_wr(UMC_OFS_CTL, 16'h0000);
                tx_data_i <= 1'b0;
                idle(4);
                #1;
                `CHK({channel_enable_o, channel_clk_en_o, channel_run_o}, 3'h0)
                `CHK({serial_tx_pin_o, serial_tx_pin_oe_n_o}, m ? 2'h1 : 2'h2)
            end
        end
        $display("test pin drive done");
        // re-enable after a cut-off transfer together with soft reset
        // busy rises right after the write, so the count starts one edge later
        bus_wr(UMC_OFS_CTL, 16'h0003);
        bus_rd(UMC_OFS_CTL, 16'h0003);
        cnt = 0;
        for (int k = 0; k < 12; k++) begin
            idle(1);
            #1;
            if (txrx_soft_reset_o === 1'b1) begin
                cnt++;
                `CHK(channel_run_o, 1'b0)
            end
        end
        `CHK(cnt, SRST_LEN)
        `CHK(channel_run_o, 1'b1)
        bus_rd(UMC_OFS_CTL, 16'h0001);
        bus_rd(UMC_OFS_MODE, 16'h0020);
        bus_rd(UMC_OFS_RATE, rate_keep);
        bus_wr(UMC_OFS_CTL, 16'h0001);
        cnt = 0;
        for (int k = 0; k < 8; k++) begin
            idle(1);
            #1;
            if (txrx_soft_reset_o !== 1'b0) begin
                cnt++;
            end
        end
        `CHK(cnt, 0)
        bus_rd(UMC_OFS_CTL, 16'h0001);
        $display("test soft reset done");
        idle(3);
        `CHK(exp_q.size(), 0)
        conclude();
    end
endmodule : umc_regs_test
